// file: rtl/stwrs_consts.svh
/*
 constants of the sensor two-wire register slave: offsets, field positions,
 reset values and bit counts. assumes inclusion by bare name, once per unit.
*/
// Operation
// - every byte moves as eight bits, most significant bit first
// - one bit per clock period; data changes only while clock is low
// - first byte: seven-bit address in bits 7..1, bit 0 one for read
// - select pin low, no override: answer address bytes 0x20 and 0x21
// - select pin high: answer address bytes 0x30 and 0x31 instead
// - slave address can be reprogrammed through configuration register 0x31FC; the code takes it at 0x31FD, and 0x31FC reads zero
// - after each byte the transmitter releases data; receiver acks by pulling low
// - data left high in ack slot is a nack; master nack ends read
// - acknowledge the address byte only when its address bits match
// - write: 16-bit register address follows, high byte first, each acked
// - write data bytes follow, each acked; stop or restart ends
// - read: after address ack device sends bytes; master acks for more
// - internal register pointer increments after every byte read or written
// - read without address phase returns data at the current pointer
// - random read: dummy write of address, repeated start, then read byte
// - sequential read: master acks each byte, device keeps supplying bytes
// - serial clock is an input only, never pulled low
// - start: data falls while clock high; stop: data rises while clock high
// - bus idle whenever clock and data are both high
`ifndef STWRS_CONSTS_SVH
`define STWRS_CONSTS_SVH

`define STWRS_ADDR_DFLT 7'h10
`define STWRS_ADDR_ALT 7'h18
`define STWRS_ADDR_REG_HI 16'h31fc
`define STWRS_ADDR_REG_LO 16'h31fd
`define STWRS_ADDR_FIELD_MSB 7
`define STWRS_ADDR_FIELD_LSB 1
`define STWRS_DIR_BIT 0
`define STWRS_PROG_RST 8'h00
`define STWRS_PTR_RST 16'h0000
`define STWRS_LAST_DATA_BIT 4'h7
`define STWRS_ACK_SLOT 4'h8
`define STWRS_CNT_RST 4'h0

`endif

// file: rtl/stwrs_pkg.sv
/*
 types of the sensor two-wire register slave.
 assumes nothing of its surroundings.
*/
package stwrs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_REG_HI = 3'b010,
        ST_REG_LO = 3'b011,
        ST_WDATA = 3'b100,
        ST_READ = 3'b101,
        ST_IGNORE = 3'b110
    } stwrs_state_t;
endpackage

// file: rtl/stwrs_bit_engine.sv
/*
 serial-clock side of the slave: bit shifting, byte and ack events, data drive.
 assumes link_clk is the master's serial clock and that control words from the
 core stay stable for the low phase in which they are used.
*/
`include "stwrs_consts.svh"

module stwrs_bit_engine (
    input wire logic link_clk,
    input wire logic reset_n,
    input wire logic frame_clear,
    input wire logic sda_i,
    input wire logic ack_en,
    input wire logic tx_mode,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte_q,
    output logic byte_tgl_q,
    output logic ack_tgl_q,
    output logic mack_q,
    output logic sda_oe_q
);
    logic [3:0] cnt_q;
    logic [6:0] sh_q;
    logic tx_stop_q;
    wire frame_rst_n = reset_n & ~frame_clear;
    wire at_last = (cnt_q == `STWRS_LAST_DATA_BIT);
    wire at_ack = (cnt_q == `STWRS_ACK_SLOT);
    wire tx_bit = tx_byte[~cnt_q[2:0]];

    // bit counter and shifter, restarted by every start or stop
    always_ff @(posedge link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt_q <= `STWRS_CNT_RST;
            sh_q <= 7'h00;
            tx_stop_q <= 1'b0;
        end else begin
            cnt_q <= at_ack ? `STWRS_CNT_RST : cnt_q + 4'h1;
            if (!at_ack) begin
                sh_q <= {sh_q[5:0], sda_i};
            end
            if (at_ack) begin
                tx_stop_q <= tx_stop_q | (tx_mode & sda_i);
            end
        end
    end

    // byte and ack results, kept across frames so toggles never jump
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_byte_q <= 8'h00;
            byte_tgl_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            mack_q <= 1'b1;
        end else begin
            if (at_last && frame_rst_n) begin
                rx_byte_q <= {sh_q, sda_i};
                byte_tgl_q <= ~byte_tgl_q;
            end
            if (at_ack && frame_rst_n) begin
                mack_q <= sda_i;
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end

    // drive only on the falling edge so data holds while clock is high
    always_ff @(negedge link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            sda_oe_q <= 1'b0;
        end else if (at_ack) begin
            sda_oe_q <= ack_en;
        end else begin
            sda_oe_q <= tx_mode & ~tx_stop_q & ~tx_bit;
        end
    end
endmodule

// file: rtl/stwrs_slave.sv
/*
 sensor two-wire register slave: start/stop detection, address match, register
 pointer, register read/write port, and the serial-clock bit engine.
 assumes the master's clock low phase lasts at least 12 clk cycles, so that the
 core answers each byte before the next falling serial clock edge.
*/
`include "stwrs_consts.svh"

module stwrs_slave (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic serial_data_line_i,
    output logic serial_data_line_o,
    output logic serial_data_line_oe,
    input wire logic address_select_pin,
    output logic [15:0] reg_addr_q,
    output logic [7:0] reg_wdata_q,
    output logic reg_wr_q,
    output logic reg_rd_q,
    input wire logic [7:0] reg_rdata
);
    stwrs_pkg::stwrs_state_t state_q;
    stwrs_pkg::stwrs_state_t state_d;
    logic [1:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic [1:0] sel_s_q;
    logic [2:0] bt_s_q;
    logic [2:0] at_s_q;
    logic frame_clear_q;
    logic ack_en_q;
    logic tx_mode_q;
    logic [7:0] tx_byte_q;
    logic [15:0] ptr_q;
    logic [7:0] prog_q;
    logic [7:0] rx_byte;
    logic mack;
    logic byte_tgl;
    logic ack_tgl;
    logic engine_oe;
    logic sent_q;

    // pins and events from the serial clock side, two flops before use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s_q <= 2'b11;
            sda_s_q <= 3'b111;
            sel_s_q <= 2'b00;
            bt_s_q <= 3'b000;
            at_s_q <= 3'b000;
        end else if (ce) begin
            scl_s_q <= {scl_s_q[0], link_clk};
            sda_s_q <= {sda_s_q[1:0], serial_data_line_i};
            sel_s_q <= {sel_s_q[0], address_select_pin};
            bt_s_q <= {bt_s_q[1:0], byte_tgl};
            at_s_q <= {at_s_q[1:0], ack_tgl};
        end
    end

    stwrs_bit_engine u_engine (
        .link_clk(link_clk),
        .reset_n(reset_n),
        .frame_clear(frame_clear_q),
        .sda_i(serial_data_line_i),
        .ack_en(ack_en_q),
        .tx_mode(tx_mode_q),
        .tx_byte(tx_byte_q),
        .rx_byte_q(rx_byte),
        .byte_tgl_q(byte_tgl),
        .ack_tgl_q(ack_tgl),
        .mack_q(mack),
        .sda_oe_q(engine_oe)
    );

    // open-drain data: only ever pulled low
    assign serial_data_line_o = 1'b0;
    assign serial_data_line_oe = engine_oe;

    // bus conditions
    wire scl_hi = scl_s_q[1];
    wire start_evt = scl_hi & sda_s_q[2] & ~sda_s_q[1];
    wire stop_evt = scl_hi & ~sda_s_q[2] & sda_s_q[1];
    wire bus_idle = scl_hi & sda_s_q[1];
    wire byte_evt = bt_s_q[2] ^ bt_s_q[1];
    wire ack_evt = at_s_q[2] ^ at_s_q[1];

    // slave address selection
    wire prog_on = |prog_q[`STWRS_ADDR_FIELD_MSB:`STWRS_ADDR_FIELD_LSB];
    wire [6:0] pin_addr = sel_s_q[1] ? `STWRS_ADDR_ALT : `STWRS_ADDR_DFLT;
    wire [6:0] own_addr = prog_on ? prog_q[7:1] : pin_addr;
    wire addr_match = (rx_byte[`STWRS_ADDR_FIELD_MSB:`STWRS_ADDR_FIELD_LSB] == own_addr);
    wire dir_read = rx_byte[`STWRS_DIR_BIT];

    // decoded actions
    wire in_addr = (state_q == stwrs_pkg::ST_ADDR);
    wire in_read = (state_q == stwrs_pkg::ST_READ);
    wire addr_ok = byte_evt & in_addr & addr_match;
    wire rd_start = addr_ok & dir_read;
    wire hi_load = byte_evt & (state_q == stwrs_pkg::ST_REG_HI);
    wire lo_load = byte_evt & (state_q == stwrs_pkg::ST_REG_LO);
    wire wr_take = byte_evt & (state_q == stwrs_pkg::ST_WDATA);
    wire rd_sent = byte_evt & in_read;
    // only an ack slot that follows a sent read byte counts as the master's answer
    wire rd_more = ack_evt & in_read & sent_q & ~mack;
    wire rd_end = ack_evt & in_read & sent_q & mack;
    wire fetch = rd_start | rd_more;
    wire own_hit_lo = (ptr_q == `STWRS_ADDR_REG_LO);
    wire own_hit = own_hit_lo | (ptr_q == `STWRS_ADDR_REG_HI);
    wire [7:0] own_rdata = own_hit_lo ? prog_q : 8'h00;
    wire prog_wr = wr_take & own_hit_lo;
    wire byte_ack = addr_ok | hi_load | lo_load | wr_take;
    wire frame_edge = start_evt | stop_evt;

    // protocol state
    always_comb begin
        state_d = state_q;
        if (start_evt) begin
            state_d = stwrs_pkg::ST_ADDR;
        end else if (stop_evt) begin
            state_d = stwrs_pkg::ST_IDLE;
        end else if (rd_end) begin
            state_d = stwrs_pkg::ST_IGNORE;
        end else if (byte_evt) begin
            unique case (state_q)
                stwrs_pkg::ST_IDLE: state_d = stwrs_pkg::ST_IDLE;
                stwrs_pkg::ST_ADDR: begin
                    if (!addr_match) begin
                        state_d = stwrs_pkg::ST_IGNORE;
                    end else if (dir_read) begin
                        state_d = stwrs_pkg::ST_READ;
                    end else begin
                        state_d = stwrs_pkg::ST_REG_HI;
                    end
                end
                stwrs_pkg::ST_REG_HI: state_d = stwrs_pkg::ST_REG_LO;
                stwrs_pkg::ST_REG_LO: state_d = stwrs_pkg::ST_WDATA;
                stwrs_pkg::ST_WDATA: state_d = stwrs_pkg::ST_WDATA;
                stwrs_pkg::ST_READ: state_d = stwrs_pkg::ST_READ;
                stwrs_pkg::ST_IGNORE: state_d = stwrs_pkg::ST_IGNORE;
                default: state_d = stwrs_pkg::ST_IDLE;
            endcase
        end
    end

    // pointer: loaded by the address phase, stepped by every data byte
    wire [15:0] ptr_d = hi_load ? {rx_byte, ptr_q[7:0]} :
                        lo_load ? {ptr_q[15:8], rx_byte} :
                        (wr_take | rd_sent) ? ptr_q + 16'h0001 : ptr_q;

    wire ack_en_d = frame_edge ? 1'b0 : byte_evt ? byte_ack : ack_evt ? 1'b0 : ack_en_q;
    wire tx_mode_d = (frame_edge | rd_end) ? 1'b0 : rd_start ? 1'b1 : tx_mode_q;
    wire sent_d = (frame_edge | ack_evt) ? 1'b0 : rd_sent ? 1'b1 : sent_q;

    // read byte sent since the last ack slot; the address ack must not fetch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sent_q <= 1'b0;
        end else if (ce) begin
            sent_q <= sent_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= stwrs_pkg::ST_IDLE;
            frame_clear_q <= 1'b1;
            ack_en_q <= 1'b0;
            tx_mode_q <= 1'b0;
            ptr_q <= `STWRS_PTR_RST;
        end else if (ce) begin
            state_q <= state_d;
            frame_clear_q <= frame_edge | (frame_clear_q & scl_hi);
            ack_en_q <= ack_en_d;
            tx_mode_q <= tx_mode_d;
            ptr_q <= ptr_d;
        end
    end

    // register port pulses, address and write data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_addr_q <= `STWRS_PTR_RST;
            reg_wdata_q <= 8'h00;
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
        end else if (ce) begin
            reg_wr_q <= wr_take & ~prog_wr;
            reg_rd_q <= fetch & ~own_hit;
            if (wr_take | fetch) begin
                reg_addr_q <= ptr_q;
            end
            if (wr_take) begin
                reg_wdata_q <= rx_byte;
            end
        end
    end

    // programmed slave address, zero falls back to the pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_q <= `STWRS_PROG_RST;
        end else if (ce && prog_wr) begin
            prog_q <= rx_byte;
        end
    end

    // byte to send: user data, or the programmed address read back
    wire [7:0] tx_byte_d = reg_rd_q ? reg_rdata : (fetch & own_hit) ? own_rdata : tx_byte_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_byte_q <= 8'h00;
        end else if (ce) begin
            tx_byte_q <= tx_byte_d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_start_to_addr: assert property (ce && start_evt |=> state_q == stwrs_pkg::ST_ADDR)
        else $error("start did not open the address phase");
    a_stop_to_idle: assert property (ce && stop_evt |=> state_q == stwrs_pkg::ST_IDLE)
        else $error("stop did not return to idle");
    a_addr_match_ack: assert property (ce && addr_ok && !frame_edge |=> ack_en_q)
        else $error("matching address byte not acknowledged");
    a_addr_miss_ignore: assert property (ce && byte_evt && in_addr && !addr_match && !frame_edge
        |=> state_q == stwrs_pkg::ST_IGNORE && !ack_en_q)
        else $error("unmatched address byte not ignored");
    a_ptr_high_load: assert property (ce && hi_load |=> ptr_q[15:8] == $past(rx_byte))
        else $error("register address high byte not loaded");
    a_write_step: assert property (ce && wr_take |=> ptr_q == $past(ptr_q) + 16'h0001
        && reg_addr_q == $past(ptr_q))
        else $error("write did not step the pointer");
    a_read_first: assert property (ce && rd_start && !own_hit && !frame_edge
        |=> reg_rd_q && reg_addr_q == $past(ptr_q) ##1 tx_byte_q == $past(reg_rdata))
        else $error("current location read fetched wrong data");
    a_nack_ends_read: assert property (ce && rd_end && !frame_edge
        |=> !tx_mode_q && state_q == stwrs_pkg::ST_IGNORE)
        else $error("master nack did not end the read");
    a_pin_address: assert property (!prog_on |-> own_addr == (sel_s_q[1] ? 7'h18 : 7'h10))
        else $error("pin selected address wrong");
    a_prog_address: assert property (ce && prog_wr && (|rx_byte[7:1])
        |=> own_addr == $past(rx_byte[7:1]))
        else $error("programmed address not taken");

    // read side
    a_read_no_ack: assert property (ce && rd_sent && !frame_edge
        |=> !ack_en_q)
        else $error("device acknowledged its own read byte");
    a_read_step: assert property (ce && rd_sent && !frame_edge
        |=> ptr_q == $past(ptr_q) + 16'h0001)
        else $error("read byte did not step the pointer");
    a_read_more: assert property (ce && rd_more && !own_hit && !frame_edge
        |=> reg_rd_q && reg_addr_q == $past(ptr_q))
        else $error("master ack did not fetch the next byte");
    a_addr_ack_nofetch: assert property (ce && ack_evt && in_read && !sent_q
        && !frame_edge |=> !reg_rd_q)
        else $error("address ack slot fetched a second byte");
    a_read_release: assert property (ce && rd_end && !frame_edge
        |=> !ack_en_q && !reg_rd_q)
        else $error("read went on after master nack");

    // write side
    a_reg_lo_load: assert property (ce && lo_load && !frame_edge
        |=> ptr_q[7:0] == $past(rx_byte) && ack_en_q)
        else $error("register address low byte not loaded");
    a_write_pulse: assert property (ce && wr_take && !prog_wr
        |=> reg_wr_q && reg_wdata_q == $past(rx_byte))
        else $error("write data not passed to the register port");
    a_prog_hidden: assert property (ce && prog_wr
        |=> !reg_wr_q && prog_q == $past(rx_byte))
        else $error("programmed address write leaked to the port");
    a_pulse_single: assert property (ce && (reg_wr_q || reg_rd_q)
        |=> !reg_wr_q && !reg_rd_q)
        else $error("register port pulse longer than one cycle");

    // address and frame
    a_addr_default: assert property (ce && addr_ok && !prog_on && !sel_s_q[1]
        |-> rx_byte == 8'h20 || rx_byte == 8'h21)
        else $error("default address byte not as expected");
    a_addr_alt: assert property (ce && addr_ok && !prog_on && sel_s_q[1]
        |-> rx_byte == 8'h30 || rx_byte == 8'h31)
        else $error("alternate address byte not as expected");
    a_dir_select: assert property (ce && addr_ok && !frame_edge
        |=> tx_mode_q == $past(rx_byte[0]))
        else $error("direction bit not followed");
    a_start_frame: assert property (ce && start_evt
        |=> frame_clear_q && !ack_en_q && !tx_mode_q)
        else $error("start did not restart the bit engine");
    a_stop_frame: assert property (ce && stop_evt
        |=> frame_clear_q && !ack_en_q && !tx_mode_q)
        else $error("stop did not release the data line");
    a_ignore_quiet: assert property (state_q == stwrs_pkg::ST_IGNORE
        |-> !ack_en_q && !tx_mode_q && !reg_wr_q)
        else $error("ignored frame still drove the bus or port");

    c_write_cycle: cover property (ce && wr_take);
    c_seq_read: cover property (ce && rd_more);
    c_addr_miss: cover property (ce && byte_evt && in_addr && !addr_match);
    c_idle_bus: cover property (bus_idle && state_q == stwrs_pkg::ST_IDLE);
    c_restart: cover property (ce && start_evt && state_q != stwrs_pkg::ST_IDLE);
endmodule

// file: sim/stwrs_master_model.sv
/*
 behavioural two-wire bus master: makes the serial clock, pulls data low.
 assumes the data wire is open drain with a pull-up, resolved by the bench.
*/
module stwrs_master_model (
    output logic link_clk,
    output logic drive_low,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_clk = 1'b1;
        drive_low = 1'b0;
    end
    // one clock period: change data in low phase, sample in high phase
    task automatic bit_cyc(input logic low, output logic seen);
        #20 drive_low = low;
        #52 link_clk = 1'b1;
        #12 seen = sda_line;
        #12 link_clk = 1'b0;
    endtask
    task automatic start_cond();
        #20 drive_low = 1'b0;
        #52 link_clk = 1'b1;
        #12 drive_low = 1'b1;
        #12 link_clk = 1'b0;
    endtask
    task automatic stop_cond();
        #20 drive_low = 1'b1;
        #52 link_clk = 1'b1;
        #12 drive_low = 1'b0;
        #12;
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(~b[i], s);
        end
        bit_cyc(1'b0, ack_n);
    endtask
    task automatic rd_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b0, s);
            b[i] = s;
        end
        bit_cyc(more, s);
    endtask
endmodule

// file: sim/sensor_two_wire_register_slave_bench.sv
/*
 bench of the two-wire register slave: master model on the link, register
 space answered combinationally. assumes the design's own assertions run inside.
*/
module sensor_two_wire_register_slave_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n = 1'b1;
    logic address_select_pin = 1'b0;
    logic link_clk, drive_low, sda, sdo, sdo_oe, reg_wr_q, reg_rd_q;
    logic [15:0] reg_addr_q;
    logic [7:0] reg_wdata_q, rb;
    int failures = 0;
    int comparisons = 0;
    logic [15:0] rq[$];
    logic [23:0] wq[$];
    logic [15:0] row_addr[3] = '{16'h1234, 16'h00ff, 16'hfffe};
    logic [7:0] row_data[3] = '{8'hab, 8'h01, 8'h80};
    always #2.5 clk = ~clk;
    assign sda = !(drive_low || (sdo_oe && !sdo));
    function automatic logic [7:0] mem(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    stwrs_slave u_stwrs_slave (.clk(clk), .reset_n(reset_n), .ce(1'b1),
        .link_clk(link_clk), .serial_data_line_i(sda), .serial_data_line_o(sdo),
        .serial_data_line_oe(sdo_oe), .address_select_pin(address_select_pin),
        .reg_addr_q(reg_addr_q), .reg_wdata_q(reg_wdata_q), .reg_wr_q(reg_wr_q),
        .reg_rd_q(reg_rd_q), .reg_rdata(mem(reg_addr_q)));
    stwrs_master_model u_stwrs_master_model (.link_clk(link_clk),
        .drive_low(drive_low), .sda_line(sda));
    always @(posedge clk) begin
        if (reg_rd_q === 1'b1) rq.push_back(reg_addr_q);
        if (reg_wr_q === 1'b1) wq.push_back({reg_addr_q, reg_wdata_q});
    end
    task automatic check(input string what, input logic [23:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic exp_n, input string what);
        logic a;
        u_stwrs_master_model.wr_byte(b, a);
        check(what, {23'h00_0000, a}, {23'h00_0000, exp_n});
    endtask
    task automatic addr_phase(input logic [7:0] dev, input logic [15:0] ra, input logic n);
        u_stwrs_master_model.start_cond();
        send(dev, n, "ack_dev");
        send(ra[15:8], n, "ack_hi");
        send(ra[7:0], n, "ack_lo");
    endtask
    task automatic do_write(input logic [7:0] dev, input logic [15:0] ra, input logic [7:0] d,
            input logic n);
        addr_phase(dev, ra, n);
        send(d, n, "ack_data");
        u_stwrs_master_model.stop_cond();
        repeat (10) @(posedge clk);
    endtask
    // read n bytes after a read address byte, first from pointer a0
    task automatic rd_seq(input logic [7:0] dev, input int n, input logic [15:0] a0);
        u_stwrs_master_model.start_cond();
        rq.delete();
        send(dev, 1'b0, "ack_rd_dev");
        for (int k = 0; k < n; k++) begin
            u_stwrs_master_model.rd_byte(k != n - 1, rb);
            check("rd_data", {16'h0000, rb}, {16'h0000, mem(a0 + k[15:0])});
        end
        u_stwrs_master_model.stop_cond();
        repeat (10) @(posedge clk);
        check("rd_count", rq.size(), n);
        for (int k = 0; k < n && k < rq.size(); k++) begin
            check("rd_addr", {8'h00, rq[k]}, {8'h00, a0 + k[15:0]});
        end
    endtask
    initial begin
        #400_000;
        failures++;
        wrap_up();
    end
    initial begin
        #1 reset_n = 1'b0;
        repeat (6) @(posedge clk);
        check("rst_out", {sdo_oe, reg_wr_q, reg_rd_q, reg_addr_q}, 24'h00_0000);
        repeat (6) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (8) @(posedge clk);
        $display("test reset done");
        for (int r = 0; r < 3; r++) begin
            wq.delete();
            do_write(8'h20, row_addr[r], row_data[r], 1'b0);
            check("wr_count", wq.size(), 1);
            check("wr_pair", wq[0], {row_addr[r], row_data[r]});
            addr_phase(8'h20, row_addr[r], 1'b0);
            rd_seq(8'h21, 1, row_addr[r]);
            $display("test row %0d done", r);
        end
        rd_seq(8'h21, 3, 16'hffff);
        $display("test current sequential done");
        #1 address_select_pin = 1'b1;
        repeat (10) @(posedge clk);
        wq.delete();
        do_write(8'h30, 16'h0040, 8'h3c, 1'b0);
        do_write(8'h20, 16'h0041, 8'h77, 1'b1);
        check("alt_wr", {8'h00, wq.size()}, 24'h00_0001);
        check("alt_pair", wq[0], 24'h00_403c);
        #1 address_select_pin = 1'b0;
        repeat (10) @(posedge clk);
        $display("test select pin done");
        wq.delete();
        do_write(8'h20, 16'h31fd, 8'h44, 1'b0);
        do_write(8'h20, 16'h0050, 8'h12, 1'b1);
        do_write(8'h44, 16'h0050, 8'h12, 1'b0);
        do_write(8'h44, 16'h31fd, 8'h00, 1'b0);
        do_write(8'h20, 16'h0051, 8'h13, 1'b0);
        check("prog_wr", {8'h00, wq.size()}, 24'h00_0002);
        check("prog_pair", wq[0], 24'h00_5012);
        $display("test programmed address done");
        wrap_up();
    end
endmodule
